// ==== verilog/ascd_decoder.sv ====
// Configuration word decoder: lower scan mask, sequence length, mode handoff.
// Assumes a 3-wire link (CS low, SCLK, DIN) from a host master.
//
// Functional notes
// R1: Select code 10101 in bits 15:11 writes the lower scan mask.
// R2: Mask bits 10..3 enable inputs 7..0; one scans; reset zero.
// R3: Select code 10110 in bits 15:11 writes the sequence length.
// R4: Sequence runs field value plus one conversions, up to 256.
// R5: Length field resets to zero, one conversion; all ones gives 256.
// R6: Word with MSB one is a configuration write.
// R7: Word with MSB zero is a mode-control instruction.
// R8: Mode word mid-sequence: finish conversion, start at next CS fall.
// R9: Config mid-sequence: finish old mode; output invalid until mode word.
// R10: Sixteen clocks with CS low per word, captured MSB first.
`timescale 1ns/1ns
`include "ascd_params.svh"

module ascd_decoder
  import ascd_pkg::*;
#(
  parameter int CONV_CYCLES = `ASCD_CONV_CYCLES
) (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_N_I,
  input  wire logic        CS_N_I,
  input  wire logic        SCLK_I,
  input  wire logic        DIN_I,
  input  wire logic        CONV_DONE_I,
  output logic [7:0]       LOW_SCAN_MASK_O,
  output logic [7:0]       SEQUENCE_COUNT_FIELD_O,
  output logic [10:0]      MODE_WORD_O,
  output logic             MODE_START_O,
  output logic             SEQ_BUSY_O,
  output logic             DATA_VALID_O,
  output logic [8:0]       CONV_LEFT_O
);
  logic        cs_fall;
  logic        word_valid;
  logic [15:0] word;

  ascd_seq_t   state;
  ascd_seq_t   next_state;
  logic [7:0]  next_mask;
  logic [7:0]  next_len;
  logic [10:0] next_mode;
  logic [10:0] pend_mode;
  logic [10:0] next_pend_mode;
  logic        next_start;
  logic        next_valid;
  logic [8:0]  left;
  logic [8:0]  next_left;
  logic        conv_tick;
  logic        next_busy;

  function automatic ascd_kind_t word_kind(input logic [15:0] w);
    // R6: MSB one is config
    if (w[15]) begin
      return ASCD_KIND_CONFIG;
    end
    // R7: MSB zero is mode control
    return ASCD_KIND_MODE;
  endfunction : word_kind

  ascd_shift #(
    .WIDTH (`ASCD_WORD_BITS)
  ) u_shift (
    .clk_i        (CLK_SYS_I),
    .rst_n_i      (RST_N_I),
    .cs_n_i       (CS_N_I),
    .sclk_i       (SCLK_I),
    .din_i        (DIN_I),
    .cs_fall_o    (cs_fall),
    .word_valid_o (word_valid),
    .word_o       (word)
  );

  // Conversion completion comes from the converter core on this clock
  assign conv_tick = CONV_DONE_I;

  always_comb begin
    next_mask      = LOW_SCAN_MASK_O;
    next_len       = SEQUENCE_COUNT_FIELD_O;
    next_mode      = MODE_WORD_O;
    next_pend_mode = pend_mode;
    next_state     = state;
    next_start     = 1'b0;
    next_valid     = DATA_VALID_O;
    next_left      = left;

    if (state == ASCD_SEQ_RUN && conv_tick) begin
      if (left <= 9'h001) begin
        next_left  = 9'h000;
        next_state = ASCD_SEQ_IDLE;
      end else begin
        next_left = left - 9'h001;
      end
    end

    if (word_valid) begin
      unique case (word_kind(word))
        ASCD_KIND_CONFIG: begin
          // R1: lower mask select
          if (word[`ASCD_SEL_HI:`ASCD_SEL_LO] == `ASCD_SEL_LOW_MASK) begin
            // R2: bits 10..3 map to inputs 7..0
            next_mask = word[`ASCD_FIELD_HI:`ASCD_FIELD_LO];
          end
          // R3: sequence length select
          if (word[`ASCD_SEL_HI:`ASCD_SEL_LO] == `ASCD_SEL_SEQ_LEN) begin
            next_len = word[`ASCD_FIELD_HI:`ASCD_FIELD_LO];
          end
          // R9: output invalid until mode word
          if (state != ASCD_SEQ_IDLE) begin
            next_valid = 1'b0;
          end
        end
        ASCD_KIND_MODE: begin
          next_pend_mode = word[10:0];
          // R8: defer to next CS fall
          next_state     = ASCD_SEQ_ARMED;
        end
        default: begin
        end
      endcase
    end else if (state == ASCD_SEQ_ARMED && cs_fall) begin
      // R8: new instruction starts here
      next_mode  = pend_mode;
      next_start = 1'b1;
      next_valid = 1'b1;
      next_state = ASCD_SEQ_RUN;
      // R4: field plus one conversions
      next_left  = {1'b0, SEQUENCE_COUNT_FIELD_O} + 9'h001;
    end

    next_busy = (next_state == ASCD_SEQ_RUN);
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state                  <= ASCD_SEQ_IDLE;
      // R2: mask resets zero
      LOW_SCAN_MASK_O        <= `ASCD_MASK_RESET;
      // R5: length resets zero
      SEQUENCE_COUNT_FIELD_O <= `ASCD_SEQ_RESET;
      MODE_WORD_O            <= 11'h000;
      pend_mode              <= 11'h000;
      MODE_START_O           <= 1'b0;
      DATA_VALID_O           <= 1'b0;
      left                   <= 9'h000;
      SEQ_BUSY_O             <= 1'b0;
      CONV_LEFT_O            <= 9'h000;
    end else begin
      state                  <= next_state;
      LOW_SCAN_MASK_O        <= next_mask;
      SEQUENCE_COUNT_FIELD_O <= next_len;
      MODE_WORD_O            <= next_mode;
      pend_mode              <= next_pend_mode;
      MODE_START_O           <= next_start;
      DATA_VALID_O           <= next_valid;
      left                   <= next_left;
      SEQ_BUSY_O             <= next_busy;
      CONV_LEFT_O            <= next_left;
    end
  end
endmodule : ascd_decoder

// ==== verilog/ascd_params.svh ====
// Constants for the scan/sequence configuration decoder.
// Assumes inclusion by the decoder package and modules only.
`ifndef ASCD_PARAMS_SVH
`define ASCD_PARAMS_SVH

`define ASCD_WORD_BITS      16
`define ASCD_SEL_HI         15
`define ASCD_SEL_LO         11
`define ASCD_FIELD_HI       10
`define ASCD_FIELD_LO       3
`define ASCD_SEL_LOW_MASK   5'h15
`define ASCD_SEL_SEQ_LEN    5'h16
`define ASCD_MASK_RESET     8'h00
`define ASCD_SEQ_RESET      8'h00
`define ASCD_CONV_NS        320
`define ASCD_CLK_NS         10
`define ASCD_CONV_CYCLES    (`ASCD_CONV_NS / `ASCD_CLK_NS)

`endif

// ==== verilog/ascd_pkg.sv ====
// Types for the scan/sequence configuration decoder.
// Assumes the params header sits beside it.
`include "ascd_params.svh"

package ascd_pkg;
  typedef enum logic [1:0] {
    ASCD_KIND_NONE,
    ASCD_KIND_CONFIG,
    ASCD_KIND_MODE
  } ascd_kind_t;

  typedef enum logic [1:0] {
    ASCD_SEQ_IDLE,
    ASCD_SEQ_ARMED,
    ASCD_SEQ_RUN
  } ascd_seq_t;
endpackage : ascd_pkg

// ==== verilog/ascd_shift.sv ====
// Serial word capture: samples the link pins and assembles 16-bit words.
// Assumes CS, SCLK and DIN are asynchronous to the system clock.
`timescale 1ns/1ns
`include "ascd_params.svh"

module ascd_shift
  import ascd_pkg::*;
#(
  parameter int WIDTH = `ASCD_WORD_BITS
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             cs_n_i,
  input  wire logic             sclk_i,
  input  wire logic             din_i,
  output logic                  cs_fall_o,
  output logic                  word_valid_o,
  output logic [WIDTH-1:0]      word_o
);
  logic [1:0]       cs_sync;
  logic [1:0]       sclk_sync;
  logic [1:0]       din_sync;
  logic             cs_prev;
  logic             sclk_prev;
  logic [WIDTH-1:0] shreg;
  logic [4:0]       bit_cnt;
  logic [WIDTH-1:0] next_shreg;
  logic [4:0]       next_bit_cnt;
  logic             next_valid;
  logic [WIDTH-1:0] next_word;
  logic             rise;
  logic             next_cs_fall;

  always_comb begin
    rise         = sclk_sync[1] && !sclk_prev && !cs_sync[1];
    next_cs_fall = cs_prev && !cs_sync[1];
    next_shreg   = shreg;
    next_bit_cnt = bit_cnt;
    next_valid   = 1'b0;
    next_word    = word_o;
    if (cs_sync[1]) begin
      next_bit_cnt = 5'h00;
    end else if (rise && bit_cnt < 5'(WIDTH)) begin
      // Clocks past the last bit are ignored
      // R10: MSB first capture
      next_shreg   = {shreg[WIDTH-2:0], din_sync[1]};
      next_bit_cnt = bit_cnt + 5'h01;
      if (bit_cnt == 5'(WIDTH - 1)) begin
        next_valid = 1'b1;
        next_word  = {shreg[WIDTH-2:0], din_sync[1]};
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_sync      <= 2'h3;
      sclk_sync    <= 2'h0;
      din_sync     <= 2'h0;
      cs_prev      <= 1'b1;
      sclk_prev    <= 1'b0;
      shreg        <= '0;
      bit_cnt      <= 5'h00;
      word_valid_o <= 1'b0;
      word_o       <= '0;
      cs_fall_o    <= 1'b0;
    end else begin
      cs_sync      <= {cs_sync[0], cs_n_i};
      sclk_sync    <= {sclk_sync[0], sclk_i};
      din_sync     <= {din_sync[0], din_i};
      cs_prev      <= cs_sync[1];
      sclk_prev    <= sclk_sync[1];
      shreg        <= next_shreg;
      bit_cnt      <= next_bit_cnt;
      word_valid_o <= next_valid;
      word_o       <= next_word;
      cs_fall_o    <= next_cs_fall;
    end
  end
endmodule : ascd_shift

// ==== tb/ascd_host.sv ====
// Host model: drives frames on chip select, serial clock and data.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ns
module ascd_host (
  input  logic clk_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
  end
  task send(input logic [15:0] w);
    // Start just after an edge so no pin moves on a sampling edge
    @(posedge clk_i) #1;
    cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      din_o = w[i];
      #62 sclk_o = 1'b1;
      #63 sclk_o = 1'b0;
    end
    #62 cs_n_o = 1'b1;
    // Released line shows the inverse
    din_o = ~din_o;
    #200;
  endtask : send
  task pulse;
    @(posedge clk_i) #1;
    cs_n_o = 1'b0;
    #100 cs_n_o = 1'b1;
    #200;
  endtask : pulse
endmodule : ascd_host

// ==== tb/ascd_checker.sv ====
// Concurrent checks on the decoder ports.
// Assumes no done pulse lands on a start cycle.
`timescale 1ns/1ns
module ascd_checker
  import ascd_pkg::*;
(
  input wire logic        CLK_SYS_I,
  input wire logic        RST_N_I,
  input wire logic        CS_N_I,
  input wire logic        SCLK_I,
  input wire logic        DIN_I,
  input wire logic        CONV_DONE_I,
  input wire logic [7:0]  LOW_SCAN_MASK_O,
  input wire logic [7:0]  SEQUENCE_COUNT_FIELD_O,
  input wire logic [10:0] MODE_WORD_O,
  input wire logic        MODE_START_O,
  input wire logic        SEQ_BUSY_O,
  input wire logic        DATA_VALID_O,
  input wire logic [8:0]  CONV_LEFT_O
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_N_I);
  mask_reset_a: assert property (RST_N_I && !$past(RST_N_I) |->
    LOW_SCAN_MASK_O == 8'h00) else $error("mask not cleared");
  len_reset_a: assert property (RST_N_I && !$past(RST_N_I) |->
    SEQUENCE_COUNT_FIELD_O == 8'h00) else $error("length not cleared");
  one_target_a: assert property ($changed(LOW_SCAN_MASK_O) |->
    $stable(SEQUENCE_COUNT_FIELD_O)) else $error("two registers written");
  start_load_a: assert property (MODE_START_O |-> ##[0:1] (SEQ_BUSY_O &&
    CONV_LEFT_O == SEQUENCE_COUNT_FIELD_O + 9'h001)) else $error("bad count");
  conv_step_a: assert property (CONV_DONE_I && SEQ_BUSY_O && CONV_LEFT_O > 9'h001
    |=> CONV_LEFT_O == $past(CONV_LEFT_O) - 9'h001) else $error("no step");
  seq_end_a: assert property (CONV_DONE_I && SEQ_BUSY_O && CONV_LEFT_O == 9'h001
    |-> ##[1:2] !SEQ_BUSY_O) else $error("busy stuck");
  start_on_fall_a: assert property (MODE_START_O |->
    $past(CS_N_I, 5) && !$past(CS_N_I, 4)) else $error("start not at select fall");
  valid_set_a: assert property ($rose(DATA_VALID_O) |->
    MODE_START_O || $past(MODE_START_O)) else $error("valid without start");
endmodule : ascd_checker

bind ascd_decoder ascd_checker chk_i (
  .CLK_SYS_I              (CLK_SYS_I),
  .RST_N_I                (RST_N_I),
  .CS_N_I                 (CS_N_I),
  .SCLK_I                 (SCLK_I),
  .DIN_I                  (DIN_I),
  .CONV_DONE_I            (CONV_DONE_I),
  .LOW_SCAN_MASK_O        (LOW_SCAN_MASK_O),
  .SEQUENCE_COUNT_FIELD_O (SEQUENCE_COUNT_FIELD_O),
  .MODE_WORD_O            (MODE_WORD_O),
  .MODE_START_O           (MODE_START_O),
  .SEQ_BUSY_O             (SEQ_BUSY_O),
  .DATA_VALID_O           (DATA_VALID_O),
  .CONV_LEFT_O            (CONV_LEFT_O)
);

// ==== tb/test_adc_scan_sequence_config_decoder.sv ====
// Self-checking bench for the scan/sequence configuration decoder.
// Assumes the host model drives the link and the bench the done pulse.
`timescale 1ns/1ns
module test_adc_scan_sequence_config_decoder
  import ascd_pkg::*;
;
  logic clk, rst_n, done, start, busy, valid;
  wire cs_n, sclk, din;
  logic [7:0] mask, len;
  logic [10:0] mword;
  logic [8:0] left;
  int n_mismatch, cmp_count, cyc, n_start;
  ascd_host h (.clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));
  ascd_decoder DUT (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CS_N_I(cs_n), .SCLK_I(sclk),
    .DIN_I(din), .CONV_DONE_I(done), .LOW_SCAN_MASK_O(mask),
    .SEQUENCE_COUNT_FIELD_O(len), .MODE_WORD_O(mword), .MODE_START_O(start),
    .SEQ_BUSY_O(busy), .DATA_VALID_O(valid), .CONV_LEFT_O(left));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Start pulses counted where they are settled
  always @(negedge clk) begin
    if (start === 1'b1) n_start++;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task cdone(input int n);
    repeat (n) begin
      @(posedge clk) #1 done = 1'b1;
      @(posedge clk) #1 done = 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    #1;
  endtask : cdone
  task t_reset;
    chk(mask, 8'h00);
    chk(len, 8'h00);
    chk({busy, valid}, 2'b00);
    $display("t_reset done");
  endtask : t_reset
  task t_cfg;
    h.send(16'hA8B8);
    chk(mask, 8'h17);
    h.send(16'h8FF8);
    chk({mask, len}, 16'h1700);
    $display("t_cfg done");
  endtask : t_cfg
  task t_seq(input logic [7:0] n);
    int s;
    h.send({5'h16, n, 3'h0});
    chk(len, n);
    s = n_start;
    h.send(16'h0123);
    chk(busy, 1'b0);
    chk(16'(n_start - s), 16'h0000);
    h.pulse();
    chk(16'(n_start - s), 16'h0001);
    chk({busy, valid, mword}, {2'b11, 11'h123});
    chk(left, n + 9'h001);
    cdone(n + 1);
    chk(busy, 1'b0);
    $display("t_seq done");
  endtask : t_seq
  task t_mid;
    h.send({5'h16, 8'h03, 3'h0});
    h.send(16'h0055);
    h.pulse();
    cdone(1);
    h.send(16'hA9E0);
    chk({busy, valid, mask}, {2'b10, 8'h3C});
    chk(left, 9'h003);
    h.send(16'h0077);
    cdone(1);
    h.pulse();
    chk({valid, mword}, {1'b1, 11'h077});
    chk(left, 9'h004);
    cdone(4);
    chk(busy, 1'b0);
    $display("t_mid done");
  endtask : t_mid
  task t_rst_mid;
    h.send({5'h16, 8'h05, 3'h0});
    h.send(16'h0321);
    h.pulse();
    chk({busy, valid, mask}, {2'b11, 8'h3C});
    @(posedge clk) #1 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({mask, len}, 16'h0000);
    chk({busy, valid, start, left}, 12'h000);
    h.send({5'h16, 8'h01, 3'h0});
    chk({busy, len}, {1'b0, 8'h01});
    $display("t_rst_mid done");
  endtask : t_rst_mid
  initial begin
    rst_n = 1'b0;
    done = 1'b0;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_reset();
    t_cfg();
    t_seq(8'h00);
    t_seq(8'hFF);
    t_seq(8'h02);
    t_mid();
    t_rst_mid();
    stop_test();
  end
endmodule : test_adc_scan_sequence_config_decoder
